//--- logic/oabd_pkg.sv
package oabd_pkg;
	localparam int unsigned INSN_W   = 16;
	localparam int unsigned WORD_W   = 32;
	localparam int unsigned PC_ADV   = 4;
	localparam logic [1:0]  SZ_BYTE  = 2'h0;
	localparam logic [1:0]  SZ_WORD  = 2'h1;
	localparam logic [1:0]  SZ_LONG  = 2'h2;
	localparam logic [1:0]  SZ_QUAD  = 2'h3;
	// status word field positions
	localparam int unsigned SW_T     = 0;
	localparam int unsigned SW_S     = 1;
	localparam int unsigned SW_Q     = 8;
	localparam int unsigned SW_M     = 9;
	localparam int unsigned SW_FD    = 15;
	localparam int unsigned SW_BL    = 28;
	localparam int unsigned SW_RB    = 29;
	localparam int unsigned SW_MD    = 30;
	localparam logic [31:0] SW_RESET = 32'h700000F0;
	// addressing mode codes
	typedef enum logic [3:0] {
		OABD_EA_NONE = 4'h0,
		OABD_EA_IND  = 4'h1,
		OABD_EA_POST = 4'h2,
		OABD_EA_PRE  = 4'h3,
		OABD_EA_DISP = 4'h4,
		OABD_EA_IDX  = 4'h5,
		OABD_EA_GDSP = 4'h6,
		OABD_EA_GIDX = 4'h7,
		OABD_EA_PCD  = 4'h8,
		OABD_BR_D8   = 4'h9,
		OABD_BR_D12  = 4'hA,
		OABD_BR_REG  = 4'hB
	} oabd_mode_t;
	// branch sequencer states
	typedef enum logic [1:0] {
		OABD_ST_RUN  = 2'b01,
		OABD_ST_SLOT = 2'b10
	} oabd_state_t;
endpackage

//--- logic/oabd_ext.sv
// immediate extension: sign or zero extend 8 bits
module oabd_ext (
	input  wire logic [7:0]  imm,
	input  wire logic        sign_en,
	output logic      [31:0] ext
);
	assign ext = sign_en ? {{24{imm[7]}}, imm} : {24'h000000, imm};
endmodule

//--- logic/oabd_agen.sv
// effective address and branch target adder, wraps modulo 2^32
module oabd_agen (
	input  wire oabd_pkg::oabd_mode_t mode,
	input  wire logic [1:0]           size,
	input  wire logic [15:0]          insn,
	input  wire logic [31:0]          pc,
	input  wire logic [31:0]          reg_n,
	input  wire logic [31:0]          reg_idx,
	input  wire logic [31:0]          gbase,
	output logic      [31:0]          ea,
	output logic      [31:0]          step
);
	logic [31:0] d4;
	logic [31:0] d8;
	logic [31:0] s8;
	logic [31:0] s12;
	logic [31:0] pc4;
	logic [31:0] pcl4;
	assign step = 32'h1 << size;
	assign d4   = {28'h0000000, insn[3:0]} << (size == oabd_pkg::SZ_LONG ? 2 : size);
	assign d8   = {24'h000000, insn[7:0]} << (size == oabd_pkg::SZ_LONG ? 2 : size);
	assign s8   = {{23{insn[7]}}, insn[7:0], 1'b0};
	assign s12  = {{19{insn[11]}}, insn[11:0], 1'b0};
	assign pc4  = pc + 32'h4;
	assign pcl4 = {pc[31:2], 2'h0} + 32'h4;
	// adders drop carry out
	always_comb
	begin
		case (mode)
			oabd_pkg::OABD_EA_IND:  ea = reg_n;
			oabd_pkg::OABD_EA_POST: ea = reg_n;
			oabd_pkg::OABD_EA_PRE:  ea = reg_n - step;
			oabd_pkg::OABD_EA_DISP: ea = reg_n + d4;
			oabd_pkg::OABD_EA_IDX:  ea = reg_n + reg_idx;
			oabd_pkg::OABD_EA_GDSP: ea = gbase + d8;
			oabd_pkg::OABD_EA_GIDX: ea = gbase + reg_idx;
			oabd_pkg::OABD_EA_PCD:  ea = (size == oabd_pkg::SZ_LONG) ? pcl4 + d8 : pc4 + d8;
			oabd_pkg::OABD_BR_D8:   ea = pc4 + s8;
			oabd_pkg::OABD_BR_D12:  ea = pc4 + s12;
			oabd_pkg::OABD_BR_REG:  ea = pc4 + reg_n;
			default:                ea = reg_n;
		endcase
	end
endmodule

//--- logic/oabd_decode.sv
// Contract
// - every instruction is one 16-bit word
// - pc used in calculations is the executing instruction's address
// - byte and word loads sign-extend to 32 bits
// - double-precision mode makes quadword float accesses undefined
// - branches except branch_if_clear/set run the next instruction first
// - delayed conditional forms have a delay slot even if not taken
// - compare_flag holds compare results; conditional branches test it
// - exception_return slot: fetch uses old privilege, data uses new
// - slot sees updated flags; control_store_read returns updated status word
// - 8-bit constants from immediate; wider ones via pc-relative loads
// - mapping_on passes addresses on; multi-space adds space_id
// - post-increment uses register then adds 1/2/4/8
// - pre-decrement subtracts 1/2/4/8 then uses result
// - 4-bit displacement zero-extended, scaled by size, plus register
// - indexed address is register plus index_zero_register
// - 8-bit displacement zero-extended, scaled, plus global_base_register
// - indexed base address is global_base_register plus index_zero_register
// - pc-relative loads: pc+4 plus scaled displacement, long masks pc
// - branch displacement sign-extended, doubled, added to pc+4
// - register branch target is pc+4 plus register
// - logic immediates zero-extend; move, add, compare immediates sign-extend
// - copy_imm loads sign-extended immediate, compare_flag untouched
module oabd_decode (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        insn_valid,
	input  wire logic [15:0] insn,
	input  wire logic [31:0] pc,
	input  wire logic [31:0] reg_n,
	input  wire logic [31:0] reg_m,
	input  wire logic [31:0] reg_idx,
	input  wire logic [31:0] global_base_register,
	input  wire logic        cmp_valid,
	input  wire logic        cmp_result,
	input  wire logic        sw_load,
	input  wire logic [31:0] sw_new,
	input  wire logic        wide_float_select,
	input  wire logic        fp_quad_access,
	input  wire logic        mapping_on,
	input  wire logic        single_space_flag,
	input  wire logic [7:0]  space_id,
	input  wire logic [31:0] load_data,
	input  wire logic [1:0]  load_size,
	output logic      [31:0] ea,
	output logic      [31:0] reg_update,
	output logic             reg_update_en,
	output logic      [31:0] imm_value,
	output logic             imm_write,
	output logic      [3:0]  imm_dest,
	output logic      [31:0] load_ext,
	output logic             branch_taken,
	output logic      [31:0] branch_target,
	output logic             in_delay_slot,
	output logic             fetch_priv,
	output logic             data_priv,
	output logic      [31:0] status_word,
	output logic             float_undefined,
	output logic             xlate_en,
	output logic             space_id_valid,
	output logic      [7:0]  space_id_out
);
	oabd_pkg::oabd_state_t state_reg;
	oabd_pkg::oabd_state_t state_next;
	oabd_pkg::oabd_mode_t  mode;
	logic [31:0] sw_reg;
	logic        md_old_reg;
	logic        slot_rte_reg;
	logic [1:0]  size;
	logic [31:0] ea_raw;
	logic [31:0] step;
	logic [31:0] ext;
	logic        sign_en;
	logic [3:0]  op;
	logic [3:0]  lo;
	logic [7:0]  hi8;
	logic        is_cond;
	logic        is_cond_dly;
	logic        is_jmp12;
	logic        is_jmpreg;
	logic        is_rte;
	logic        is_delayed;
	logic        t_flag;
	logic        is_copy;
	logic        is_imm_op;
	logic        go;
	logic [31:0] base_reg;

	assign op  = insn[15:12];
	assign lo  = insn[3:0];
	assign hi8 = insn[15:8];
	assign t_flag = sw_reg[oabd_pkg::SW_T];
	assign go = insn_valid;

	// branch class decode
	assign is_cond     = (hi8 == 8'h89) || (hi8 == 8'h8B) || (hi8 == 8'h8D) || (hi8 == 8'h8F);
	assign is_cond_dly = (hi8 == 8'h8D) || (hi8 == 8'h8F);
	assign is_jmp12    = (op == 4'hA) || (op == 4'hB);
	assign is_jmpreg   = (op == 4'h0) && (insn[7:0] == 8'h23 || insn[7:0] == 8'h03);
	assign is_rte      = (insn == 16'h002B);
	assign is_delayed  = is_jmp12 || is_jmpreg || is_rte || is_cond_dly;

	// taken when flag matches sense bit (hi8[1] clear means branch on clear)
	assign branch_taken = go && (state_reg == oabd_pkg::OABD_ST_RUN) && (is_jmp12 || is_jmpreg ||
		(is_cond && (t_flag == hi8[1])));

	// operand size from the low opcode bits of move forms
	assign size = (hi8 == 8'hC7) ? oabd_pkg::SZ_LONG :
		(op == 4'h8 || op == 4'hC) ? insn[9:8] :
		(op == 4'h1 || op == 4'h5 || op == 4'hD) ? oabd_pkg::SZ_LONG :
		(op == 4'h9) ? oabd_pkg::SZ_WORD : lo[1:0];

	// addressing mode select
	assign mode = is_cond ? oabd_pkg::OABD_BR_D8 :
		is_jmp12 ? oabd_pkg::OABD_BR_D12 :
		is_jmpreg ? oabd_pkg::OABD_BR_REG :
		(op == 4'h9 || op == 4'hD) ? oabd_pkg::OABD_EA_PCD :
		(hi8 == 8'hC7) ? oabd_pkg::OABD_EA_PCD :
		(op == 4'hC && insn[11:10] == 2'h3) ? oabd_pkg::OABD_EA_GIDX :
		(op == 4'hC) ? oabd_pkg::OABD_EA_GDSP :
		(op == 4'h8 || op == 4'h1 || op == 4'h5) ? oabd_pkg::OABD_EA_DISP :
		(op == 4'h0 && lo[3:2] != 2'h0 && lo[1:0] != 2'h3) ? oabd_pkg::OABD_EA_IDX :
		(op == 4'h2 && lo[3:2] == 2'h1) ? oabd_pkg::OABD_EA_PRE :
		(op == 4'h6 && lo[3:2] == 2'h1) ? oabd_pkg::OABD_EA_POST :
		(op == 4'h2 || op == 4'h6) ? oabd_pkg::OABD_EA_IND : oabd_pkg::OABD_EA_NONE;

	// base register: source field for loads, post-increment and register branches
	assign base_reg = (op == 4'h6 || op == 4'h5 || op == 4'h0) ? reg_m : reg_n;

	oabd_agen u_agen (
		.mode    (mode),
		.size    (size),
		.insn    (insn),
		.pc      (pc),
		.reg_n   (base_reg),
		.reg_idx (reg_idx),
		.gbase   (global_base_register),
		.ea      (ea_raw),
		.step    (step)
	);

	// immediate class: logic ops zero-extend, others sign-extend
	assign sign_en   = !(op == 4'hC && insn[11]);
	assign is_copy   = (op == 4'hE);
	assign is_imm_op = is_copy || (op == 4'h7) || (hi8 == 8'h88) || (op == 4'hC && insn[11]);

	oabd_ext u_ext (
		.imm     (insn[7:0]),
		.sign_en (sign_en),
		.ext     (ext)
	);

	assign imm_value     = is_imm_op ? ext : 32'h00000000;
	assign imm_write     = go && is_copy;
	assign imm_dest      = insn[11:8];
	assign ea            = ea_raw;
	assign branch_target = ea_raw;
	assign reg_update    = (mode == oabd_pkg::OABD_EA_POST) ? reg_m + step : ea_raw;
	assign reg_update_en = go && (mode == oabd_pkg::OABD_EA_POST || mode == oabd_pkg::OABD_EA_PRE);

	// load extension by size
	assign load_ext = (load_size == oabd_pkg::SZ_BYTE) ? {{24{load_data[7]}}, load_data[7:0]} :
		(load_size == oabd_pkg::SZ_WORD) ? {{16{load_data[15]}}, load_data[15:0]} :
		load_data;

	assign float_undefined = wide_float_select && fp_quad_access;
	assign xlate_en   = mapping_on;
	assign space_id_valid = mapping_on && !single_space_flag;
	assign space_id_out   = space_id_valid ? space_id : 8'h00;

	// privilege split in exception_return slot
	assign fetch_priv    = slot_rte_reg ? md_old_reg : sw_reg[oabd_pkg::SW_MD];
	assign data_priv     = sw_reg[oabd_pkg::SW_MD];
	assign status_word   = sw_reg;
	assign in_delay_slot = (state_reg == oabd_pkg::OABD_ST_SLOT);

	// sequencer next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			oabd_pkg::OABD_ST_RUN:
				if (go && is_delayed)
					state_next = oabd_pkg::OABD_ST_SLOT;
			oabd_pkg::OABD_ST_SLOT:
				if (go)
					state_next = oabd_pkg::OABD_ST_RUN;
			default:
				state_next = oabd_pkg::OABD_ST_RUN;
		endcase
	end

	// state and status word
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg    <= oabd_pkg::OABD_ST_RUN;
			sw_reg       <= oabd_pkg::SW_RESET;
			md_old_reg   <= 1'b1;
			slot_rte_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			if (sw_load)
				sw_reg <= sw_new;
			else if (cmp_valid)
				sw_reg[oabd_pkg::SW_T] <= cmp_result;
			if (go && state_reg == oabd_pkg::OABD_ST_RUN && is_rte)
			begin
				md_old_reg   <= sw_reg[oabd_pkg::SW_MD];
				slot_rte_reg <= 1'b1;
			end
			else if (go)
				slot_rte_reg <= 1'b0;
		end
	end

	a_slot_follows: assert property (@(posedge clk) disable iff (rst)
		(go && state_reg == oabd_pkg::OABD_ST_RUN && is_delayed) |=> in_delay_slot)
		else $error("delay slot missing");
	a_cond_slot: assert property (@(posedge clk) disable iff (rst)
		(go && !in_delay_slot && is_cond_dly && !branch_taken) |=> in_delay_slot)
		else $error("untaken delayed branch lost slot");
	a_rte_fetch_md: assert property (@(posedge clk) disable iff (rst)
		(go && !in_delay_slot && is_rte) |=> fetch_priv == $past(sw_reg[oabd_pkg::SW_MD]))
		else $error("slot fetch privilege wrong");
	a_copy_flag: assert property (@(posedge clk) disable iff (rst)
		(is_copy && go && !cmp_valid && !sw_load) |=> $stable(status_word[0]))
		else $error("copy changed compare flag");
	a_copy_sign: assert property (@(posedge clk) disable iff (rst)
		is_copy |-> imm_value[31:8] == {24{insn[7]}})
		else $error("copy immediate not sign extended");
	a_space_id_gate: assert property (@(posedge clk) disable iff (rst)
		space_id_valid |-> (mapping_on && !single_space_flag && space_id_out == space_id))
		else $error("space id gating wrong");
	a_quad_undef: assert property (@(posedge clk) disable iff (rst)
		(wide_float_select && fp_quad_access) |-> float_undefined)
		else $error("undefined flag missing");
	a_load_sext: assert property (@(posedge clk) disable iff (rst)
		(load_size == 2'h0) |-> load_ext[31:8] == {24{load_data[7]}})
		else $error("byte load not sign extended");
	a_cmp_record: assert property (@(posedge clk) disable iff (rst)
		(cmp_valid && !sw_load) |=> status_word[0] == $past(cmp_result))
		else $error("compare result not recorded");
	a_bra_target: assert property (@(posedge clk) disable iff (rst)
		(go && is_jmp12) |-> branch_target == pc + 32'h4 + {{19{insn[11]}}, insn[11:0], 1'b0})
		else $error("branch target wrong");
	a_post_addr: assert property (@(posedge clk) disable iff (rst)
		(go && mode == oabd_pkg::OABD_EA_POST) |-> ea == base_reg)
		else $error("post-increment address wrong");
	a_post_step: assert property (@(posedge clk) disable iff (rst)
		(go && mode == oabd_pkg::OABD_EA_POST) |-> reg_update == base_reg + (32'h1 << size))
		else $error("post-increment step wrong");
	a_pre_addr: assert property (@(posedge clk) disable iff (rst)
		(go && mode == oabd_pkg::OABD_EA_PRE) |-> ea == base_reg - (32'h1 << size))
		else $error("pre-decrement address wrong");
	a_pre_write: assert property (@(posedge clk) disable iff (rst)
		(go && mode == oabd_pkg::OABD_EA_PRE) |-> (reg_update_en && reg_update == ea))
		else $error("pre-decrement write-back wrong");
	a_disp_long: assert property (@(posedge clk) disable iff (rst)
		(go && op == 4'h5) |-> ea == base_reg + {26'h0, insn[3:0], 2'h0})
		else $error("long displacement address wrong");
	a_disp_byte: assert property (@(posedge clk) disable iff (rst)
		(go && hi8 == 8'h84) |-> ea == base_reg + {28'h0, insn[3:0]})
		else $error("byte displacement address wrong");
	a_idx_sum: assert property (@(posedge clk) disable iff (rst)
		(go && mode == oabd_pkg::OABD_EA_IDX) |-> ea == base_reg + reg_idx)
		else $error("indexed address wrong");
	a_gbr_word: assert property (@(posedge clk) disable iff (rst)
		(go && hi8 == 8'hC5) |-> ea == global_base_register + {23'h0, insn[7:0], 1'b0})
		else $error("base displacement address wrong");
	a_gbr_idx: assert property (@(posedge clk) disable iff (rst)
		(go && mode == oabd_pkg::OABD_EA_GIDX) |-> ea == global_base_register + reg_idx)
		else $error("indexed base address wrong");
	a_pc_word: assert property (@(posedge clk) disable iff (rst)
		(go && op == 4'h9) |-> ea == pc + 32'h4 + {23'h0, insn[7:0], 1'b0})
		else $error("pc-relative word address wrong");
	a_pc_long: assert property (@(posedge clk) disable iff (rst)
		(go && (op == 4'hD || hi8 == 8'hC7)) |->
		ea == {pc[31:2], 2'h0} + 32'h4 + {22'h0, insn[7:0], 2'h0})
		else $error("pc-relative long address wrong");
	a_cond_target: assert property (@(posedge clk) disable iff (rst)
		(go && is_cond) |-> branch_target == pc + 32'h4 + {{23{insn[7]}}, insn[7:0], 1'b0})
		else $error("conditional target wrong");
	a_reg_target: assert property (@(posedge clk) disable iff (rst)
		(go && is_jmpreg) |-> branch_target == pc + 32'h4 + base_reg)
		else $error("register branch target wrong");
	a_slot_no_take: assert property (@(posedge clk) disable iff (rst)
		in_delay_slot |-> !branch_taken)
		else $error("branch taken in delay slot");
	a_logic_zext: assert property (@(posedge clk) disable iff (rst)
		(op == 4'hC && insn[11]) |-> imm_value[31:8] == 24'h000000)
		else $error("logic immediate not zero extended");
	a_word_sext: assert property (@(posedge clk) disable iff (rst)
		(load_size == oabd_pkg::SZ_WORD) |-> load_ext[31:16] == {16{load_data[15]}})
		else $error("word load not sign extended");
	a_rte_data_md: assert property (@(posedge clk) disable iff (rst)
		sw_load |=> data_priv == $past(sw_new[oabd_pkg::SW_MD]))
		else $error("slot data privilege wrong");
	a_sw_update: assert property (@(posedge clk) disable iff (rst)
		sw_load |=> status_word == $past(sw_new))
		else $error("status word not updated");
endmodule

//--- testbench/oabd_mem_model.sv
// data memory seen by the load path: a small longword table
module oabd_mem_model (
	input  wire logic [31:0] addr,
	output logic      [31:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [16];
	// mixed sign bits in every byte lane so both extensions show
	initial
	begin
		for (int i = 0; i < 16; i++)
			mem[i] = 32'h9E37_79B9 * 32'(i + 1);
	end
	// longword-aligned lookup, answers in the same cycle
	assign rdata = mem[addr[5:2]];
endmodule

//--- testbench/tb_top.sv
`define OABD_CMP(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef enum logic [3:0] {C_EA, C_RU, C_BT, C_TK, C_DS, C_IM, C_IW, C_LX, C_FU, C_XL,
		C_AS, C_PV, C_SW, C_RE, C_T} oabd_sel_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        insn_valid, cmp_valid, cmp_result, sw_load, wide_float_select, fp_quad_access;
	logic        mapping_on, single_space_flag, reg_update_en, imm_write, branch_taken;
	logic        in_delay_slot, fetch_priv, data_priv, float_undefined, xlate_en, space_id_valid;
	logic [15:0] insn;
	logic [31:0] pc, reg_n, reg_m, reg_idx, global_base_register, sw_new, load_data;
	logic [31:0] ea, reg_update, imm_value, load_ext, branch_target, status_word;
	logic [31:0] r, x, g, p, nv, ld, got, want;
	logic [11:0] d;
	logic [7:0]  space_id, space_id_out;
	logic [3:0]  imm_dest;
	logic [1:0]  load_size;
	logic [63:0] iops = 64'h88C8C9CACBCE71E1;
	logic [7:0]  sxm = 8'hC1;
	oabd_sel_t   q_sel [$];
	logic [31:0] q_val [$];
	int          bad_count, total_checks;
	int          seed = 27733;

	always #4 clk = ~clk;

	oabd_decode dut_u (.clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn), .pc(pc),
		.reg_n(reg_n), .reg_m(reg_m), .reg_idx(reg_idx),
		.global_base_register(global_base_register), .cmp_valid(cmp_valid),
		.cmp_result(cmp_result), .sw_load(sw_load), .sw_new(sw_new),
		.wide_float_select(wide_float_select), .fp_quad_access(fp_quad_access),
		.mapping_on(mapping_on), .single_space_flag(single_space_flag), .space_id(space_id),
		.load_data(load_data), .load_size(load_size), .ea(ea), .reg_update(reg_update),
		.reg_update_en(reg_update_en), .imm_value(imm_value), .imm_write(imm_write),
		.imm_dest(imm_dest), .load_ext(load_ext), .branch_taken(branch_taken),
		.branch_target(branch_target), .in_delay_slot(in_delay_slot), .fetch_priv(fetch_priv),
		.data_priv(data_priv), .status_word(status_word), .float_undefined(float_undefined),
		.xlate_en(xlate_en), .space_id_valid(space_id_valid), .space_id_out(space_id_out));

	oabd_mem_model mem_u (.addr(ea), .rdata(load_data));

	function automatic logic [31:0] obs(input oabd_sel_t s);
		case (s)
			C_EA: return ea;
			C_RU: return reg_update;
			C_BT: return branch_target;
			C_TK: return {31'h0, branch_taken};
			C_DS: return {31'h0, in_delay_slot};
			C_IM: return imm_value;
			C_IW: return {27'h0, imm_write, imm_dest};
			C_LX: return load_ext;
			C_FU: return {31'h0, float_undefined};
			C_XL: return {30'h0, xlate_en, space_id_valid};
			C_AS: return {24'h0, space_id_out};
			C_PV: return {30'h0, fetch_priv, data_priv};
			C_SW: return status_word;
			C_RE: return {31'h0, reg_update_en};
			default: return {31'h0, status_word[0]};
		endcase
	endfunction

	task automatic put(input oabd_sel_t s, input logic [31:0] v);
		q_sel.push_back(s);
		q_val.push_back(v);
	endtask

	task automatic issue(input logic [15:0] i);
		@(negedge clk);
		insn = i;
		insn_valid = 1'b1;
		cmp_valid = 1'b0;
		sw_load = 1'b0;
	endtask

	task automatic cmp(input logic v);
		@(negedge clk);
		insn_valid = 1'b0;
		cmp_valid = 1'b1;
		cmp_result = v;
	endtask

	task automatic final_report;
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// drain the notes at the edge where the results are sampled
	always @(posedge clk)
		while (q_sel.size() > 0)
		begin
			got = obs(q_sel.pop_front());
			want = q_val.pop_front();
			`OABD_CMP(got, want)
		end

	// hang guard
	initial
	begin
		#100000;
		bad_count++;
		final_report();
	end

	// stimulus on falling edges
	initial
	begin
		{insn_valid, cmp_valid, cmp_result, sw_load, wide_float_select, fp_quad_access} = 6'h00;
		{mapping_on, single_space_flag, space_id, load_size, insn} = 28'h0;
		{pc, reg_n, reg_m, reg_idx, global_base_register, sw_new} = 192'h0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		put(C_SW, 32'h7000_00F0);
		put(C_PV, 32'h3);
		put(C_DS, 32'h0);
		for (int k = 0; k < 8; k++)
		begin
			@(negedge clk);
			insn_valid = 1'b0;
			r = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
			x = $random(seed);
			g = (k == 0) ? 32'hFFFF_FFF0 : $random(seed);
			p = (k == 0) ? 32'hFFFF_FFFE : $random(seed) & 32'hFFFF_FFFE;
			d = 12'($random(seed));
			{reg_n, reg_m, reg_idx, global_base_register, pc} = {r, r, x, g, p};
			issue(16'h0123);
			put(C_BT, p + 32'h4 + r);
			for (int s = 0; s < 3; s++)
			begin
				issue(16'h6124 | 16'(s));
				put(C_EA, r);
				put(C_RU, r + (32'h1 << s));
				put(C_RE, 32'h1);
				issue(16'h2124 | 16'(s));
				put(C_EA, r - (32'h1 << s));
				put(C_RU, r - (32'h1 << s));
				put(C_RE, 32'h1);
				issue({8'hC4 | 8'(s), d[7:0]});
				put(C_EA, g + ({24'h0, d[7:0]} << s));
				put(C_RE, 32'h0);
			end
			issue({4'hA, d});
			put(C_BT, p + 32'h4 + {{19{d[11]}}, d, 1'b0});
			issue({8'h84, 4'h2, d[3:0]});
			put(C_EA, r + {28'h0, d[3:0]});
			issue({8'h85, 4'h2, d[3:0]});
			put(C_EA, r + {27'h0, d[3:0], 1'b0});
			issue({8'h51, 4'h2, d[3:0]});
			put(C_EA, r + {26'h0, d[3:0], 2'h0});
			issue(16'h012C);
			put(C_EA, r + x);
			issue({8'hCD, d[7:0]});
			put(C_EA, g + x);
			issue({8'h91, d[7:0]});
			put(C_EA, p + 32'h4 + {23'h0, d[7:0], 1'b0});
			issue({8'hD1, d[7:0]});
			put(C_EA, (p & 32'hFFFF_FFFC) + 32'h4 + {22'h0, d[7:0], 2'h0});
			issue({8'hC7, d[7:0]});
			put(C_EA, (p & 32'hFFFF_FFFC) + 32'h4 + {22'h0, d[7:0], 2'h0});
			issue({8'hCF, d[7:0]});
			put(C_EA, g + x);
			issue({8'h8B, d[7:0]});
			put(C_BT, p + 32'h4 + {{23{d[7]}}, d[7:0], 1'b0});
		end
		// immediates, with the flag set beforehand
		cmp(1'b1);
		for (int i = 0; i < 8; i++)
		begin
			issue({iops[63 - 8 * i -: 8], 8'h80 | 8'($random(seed))});
			put(C_IM, sxm[i] ? {24'hFF_FFFF, insn[7:0]} : {24'h0, insn[7:0]});
		end
		put(C_IW, 32'h11);
		issue(16'h6124);
		put(C_T, 32'h1);
		// conditional and delayed branches
		issue(16'h8B02); // sense bit set: branch on set
		put(C_TK, 32'h1);
		put(C_BT, pc + 32'h8);
		issue(16'h6124);
		put(C_DS, 32'h0);
		cmp(1'b0);
		issue(16'h8B02);
		put(C_TK, 32'h0);
		issue(16'h8902); // sense bit clear: branch on clear
		put(C_TK, 32'h1);
		issue(16'h8F02); // delayed branch on set, flag clear
		put(C_DS, 32'h0);
		put(C_TK, 32'h0);
		issue(16'hA005);
		put(C_DS, 32'h1);
		put(C_TK, 32'h0);
		issue(16'hA005);
		put(C_DS, 32'h0);
		put(C_TK, 32'h1);
		put(C_BT, pc + 32'hE);
		issue(16'h6124);
		put(C_DS, 32'h1);
		// return from exception into user level
		nv = $random(seed) & 32'hBFFF_FFFF;
		@(negedge clk);
		insn = 16'h002B;
		insn_valid = 1'b1;
		sw_load = 1'b1;
		sw_new = nv;
		issue(16'h6124);
		put(C_SW, nv);
		put(C_PV, 32'h2);
		put(C_DS, 32'h1);
		issue(16'h6124);
		put(C_PV, 32'h0);
		// load extension, float and translation controls
		for (int k = 0; k < 16; k++)
		begin
			@(negedge clk);
			insn_valid = 1'b0;
			{single_space_flag, mapping_on, fp_quad_access, wide_float_select} = 4'(k);
			load_size = 2'(k % 3);
			space_id = 8'($random(seed));
			reg_n = $random(seed);
			reg_m = reg_n;
			#1;
			ld = load_data;
			put(C_LX, (load_size == 2'h0) ? {{24{ld[7]}}, ld[7:0]} :
				(load_size == 2'h1) ? {{16{ld[15]}}, ld[15:0]} : ld);
			put(C_FU, {31'h0, wide_float_select & fp_quad_access});
			put(C_XL, {30'h0, mapping_on, mapping_on & ~single_space_flag});
			if (mapping_on && !single_space_flag)
				put(C_AS, {24'h0, space_id});
		end
		repeat (2) @(posedge clk);
		final_report();
	end
endmodule
